// ### pcrb_pkg.sv
// constants, types and register map of the paged control register bank
package pcrb_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] SHARED_STATUS_SELECT_OFFSET = 8'h0C;
  localparam logic [7:0] SHARED_INIT_CONTROL_OFFSET = 8'hE2;
  localparam logic [7:0] REVISION_CODE_OFFSET = 8'hF0;
  localparam logic [7:0] PART_IDENTIFIER_OFFSET = 8'hF1;
  localparam logic [7:0] PAGE_AND_PIN_CONTROL_OFFSET = 8'hFF;
  localparam logic [7:0] RECOVERY_PAGE_RESET_OFFSET = 8'h00;
  localparam logic [7:0] SIGNAL_LOSS_STATUS_OFFSET = 8'h01;
  localparam logic [7:0] RECOVERY_LOOP_STATUS_OFFSET = 8'h02;
  localparam logic [7:0] MANUAL_BOOST_CONTROL_OFFSET = 8'h03;
  localparam logic [7:0] RESERVED_FOUR_OFFSET = 8'h04;
  localparam logic [7:0] RESERVED_FIVE_OFFSET = 8'h05;
  localparam logic [7:0] BOOST_OVERRIDE_OFFSET = 8'h2D;
  localparam logic [7:0] APPLIED_BOOST_OFFSET = 8'h52;
  localparam logic [7:0] EVENT_MASK_OFFSET = 8'h56;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] SHARED_STATUS_SELECT_RESET = 8'h08;
  localparam logic [7:0] SHARED_INIT_CONTROL_RESET = 8'h10;
  localparam logic [7:0] PAGE_AND_PIN_CONTROL_RESET = 8'h00;
  localparam logic [7:0] RECOVERY_PAGE_RESET_RESET = 8'h00;
  localparam logic [7:0] SIGNAL_LOSS_STATUS_RESET = 8'h03;
  localparam logic [7:0] RECOVERY_LOOP_STATUS_RESET = 8'h41;
  localparam logic [7:0] MANUAL_BOOST_CONTROL_RESET = 8'h80;
  localparam logic [7:0] RESERVED_FOUR_RESET = 8'h00;
  localparam logic [7:0] RESERVED_FIVE_RESET = 8'h00;
  localparam logic [7:0] BOOST_OVERRIDE_RESET = 8'h00;
  localparam logic [7:0] EVENT_MASK_RESET = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int INIT_TRIGGER_BIT = 0;
  localparam int INIT_DONE_BIT = 4;
  localparam int PIN_SELECT_LSB = 4;
  localparam int PAGE_ENABLE_BIT = 2;
  localparam int PAGE_SELECT_LSB = 0;
  localparam int PAGE_CLEAR_BIT = 2;
  localparam int LOSS_FLAG_BIT = 1;
  localparam int STATUS_SELECT_LSB = 4;
  localparam int OVERRIDE_BIT = 3;
  localparam int STAGE0_LSB = 6;
  localparam int STAGE1_LSB = 4;
  localparam int STAGE2_LSB = 2;
  localparam int STAGE3_LSB = 0;
  localparam int EVENT_COUNT = 7;

  // ****************************************************************
  // codes
  // ****************************************************************
  localparam logic [1:0] PAGE_CODE_RECOVERY = 2'h0;
  localparam logic [1:0] PAGE_CODE_DRIVER = 2'h1;

  typedef enum logic [1:0] {
    PIN_LOCK = 2'b00,
    PIN_RESERVED = 2'b01,
    PIN_LOSS = 2'b10,
    PIN_EVENTS = 2'b11
  } pcrb_pin_mode_type;

  typedef enum logic [1:0] {
    TARGET_SHARED = 2'b00,
    TARGET_RECOVERY = 2'b01,
    TARGET_DRIVER = 2'b10,
    TARGET_NONE = 2'b11
  } pcrb_target_type;

  typedef enum logic [1:0] {
    INIT_IDLE = 2'b00,
    INIT_LOAD = 2'b01
  } pcrb_init_state_type;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int INIT_LOAD_TIME_NS = 160;
  localparam int INIT_LOAD_CYCLES =
    (INIT_LOAD_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ****************************************************************
  // host access carrier
  // ****************************************************************
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] address;
    logic [7:0] write_data;
  } pcrb_access_type;

endpackage : pcrb_pkg

// ### pcrb_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module pcrb_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit changes only once the second and third stages agree
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_out <= RESET_VALUE;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  end

endmodule : pcrb_sync

`default_nettype wire

// ### pcrb_bank.sv
// paged configuration and status register bank of the reclocking receiver
//
// How it works
// R1: init-done flag, bit 4 at 0xE2, reads 0 while loading, 1 after.
// R2: writing 1 to bit 0 at 0xE2 starts the settings load sequence.
// R3: read-only part identifier at 0xF1, with read-only revision at 0xF0.
// R4: pin select bits 5:4 pick lock, reserved, input loss, or masked events.
// R5: window enable bit 2 at 0xFF off: shared page; on: pointer page.
// R6: pointer 00 selects recovery page, 01 driver page; others invalid.
// R7: bit 2 at recovery 0x00 clears that page to defaults, then self-clears.
// R8: host re-initialises the recovery page after clearing it.
// R9: bit 1 of loss status reads 1 while first input signal is lost.
// R10: recovery status byte content picked by shared status select field.
// R11: manual boost stages apply only while override bit 0x2D[3] is set.
// R12: boost register holds stage 0..3 controls at 7:6, 5:4, 3:2, 1:0.
// R13: applied equalizer boost is readable at recovery page 0x52.
// R14: after reset host accesses go to the shared page.
// R15: registers are 8 bits at 8-bit offsets; reserved bits just store. Here 0xE2 bits 7:5 are not stored and read 0.
`timescale 1ns/10ps
`default_nettype none

module pcrb_bank #(
  // arbitrary neutral identification values
  parameter logic [7:0] REVISION_VALUE = 8'h5A,
  parameter logic [7:0] IDENTIFIER_VALUE = 8'hA5,
  parameter int INIT_CYCLES = pcrb_pkg::INIT_LOAD_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire pcrb_pkg::pcrb_access_type host_access,
  output logic [7:0] read_data,
  output logic read_valid,
  input wire logic recovery_lock,
  input wire logic first_input_loss,
  input wire logic [15:0][7:0] status_sources,
  input wire logic [7:0] adaptive_boost,
  input wire logic [pcrb_pkg::EVENT_COUNT-1:0] event_sources,
  output logic lock_n,
  output logic [7:0] applied_boost,
  output logic init_busy
);

  import pcrb_pkg::*;

  localparam int COUNT_WIDTH = $clog2(INIT_CYCLES + 1);
  localparam logic [COUNT_WIDTH-1:0] COUNT_LAST =
    COUNT_WIDTH'(INIT_CYCLES - 1);

  // ****************************************************************
  // functions
  // ****************************************************************
  // 0xFF stays reachable from every page so the host can always leave it
  function automatic pcrb_target_type target_of(
    input logic [7:0] address,
    input logic [7:0] page_control
  );
    pcrb_target_type result;
    result = TARGET_SHARED;
    if (address != PAGE_AND_PIN_CONTROL_OFFSET &&
        page_control[PAGE_ENABLE_BIT]) begin // [R5]
      unique case (page_control[PAGE_SELECT_LSB +: 2])
        PAGE_CODE_RECOVERY: result = TARGET_RECOVERY; // [R6]
        PAGE_CODE_DRIVER: result = TARGET_DRIVER; // [R6]
        default: result = TARGET_NONE;
      endcase
    end
    return result;
  endfunction : target_of

  function automatic logic [7:0] boost_in_use(
    input logic override_on,
    input logic [7:0] manual,
    input logic [7:0] adaptive
  );
    logic [7:0] result;
    result = adaptive;
    if (override_on) begin // [R11]
      result = {manual[STAGE0_LSB +: 2], manual[STAGE1_LSB +: 2],
                manual[STAGE2_LSB +: 2], manual[STAGE3_LSB +: 2]}; // [R12]
    end
    return result;
  endfunction : boost_in_use

  // ****************************************************************
  // input synchronisation
  // ****************************************************************
  logic lock_synced;
  logic loss_synced;
  logic [EVENT_COUNT-1:0] events_synced;

  pcrb_sync #(
    .WIDTH(EVENT_COUNT + 2),
    .RESET_VALUE({{EVENT_COUNT{1'b0}}, 1'b0, 1'b1})
  ) input_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({event_sources, recovery_lock, first_input_loss}),
    .sync_out({events_synced, lock_synced, loss_synced})
  );

  // ****************************************************************
  // access decode
  // ****************************************************************
  logic [7:0] page_and_pin_control;
  pcrb_target_type target;
  logic shared_write;
  logic recovery_write;

  assign target = target_of(host_access.address, page_and_pin_control);
  assign shared_write = host_access.write && target == TARGET_SHARED;
  assign recovery_write = host_access.write && target == TARGET_RECOVERY;

  function automatic logic hit(
    input logic strobe,
    input logic [7:0] address,
    input logic [7:0] offset
  );
    return strobe && address == offset;
  endfunction : hit

  // ****************************************************************
  // shared page registers
  // ****************************************************************
  logic [7:0] shared_status_select;
  logic [3:1] init_reserved;
  logic init_trigger;
  logic init_finish;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      page_and_pin_control <= PAGE_AND_PIN_CONTROL_RESET; // [R14]
    end else if (hit(shared_write, host_access.address,
                     PAGE_AND_PIN_CONTROL_OFFSET)) begin
      page_and_pin_control <= host_access.write_data; // [R15]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shared_status_select <= SHARED_STATUS_SELECT_RESET;
    end else if (hit(shared_write, host_access.address,
                     SHARED_STATUS_SELECT_OFFSET)) begin
      shared_status_select <= host_access.write_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      init_reserved <= SHARED_INIT_CONTROL_RESET[3:1];
    end else if (hit(shared_write, host_access.address,
                     SHARED_INIT_CONTROL_OFFSET)) begin
      init_reserved <= host_access.write_data[3:1]; // [R15]
    end
  end

  // trigger bit stays set while loading, then clears itself
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      init_trigger <= SHARED_INIT_CONTROL_RESET[INIT_TRIGGER_BIT];
    end else if (init_finish) begin
      init_trigger <= 1'b0;
    end else if (hit(shared_write, host_access.address,
                     SHARED_INIT_CONTROL_OFFSET) &&
                 host_access.write_data[INIT_TRIGGER_BIT]) begin
      init_trigger <= 1'b1; // [R2]
    end
  end

  // ****************************************************************
  // settings load sequence
  // ****************************************************************
  pcrb_init_state_type init_state;
  logic [COUNT_WIDTH-1:0] init_count;
  logic init_start;

  assign init_start = init_state == INIT_IDLE &&
                      hit(shared_write, host_access.address,
                          SHARED_INIT_CONTROL_OFFSET) &&
                      host_access.write_data[INIT_TRIGGER_BIT]; // [R2]
  assign init_finish = init_state == INIT_LOAD && init_count == '0;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      init_state <= INIT_IDLE;
      init_count <= '0;
    end else begin
      unique case (init_state)
        INIT_IDLE: begin
          if (init_start) begin
            init_state <= INIT_LOAD; // [R2]
            init_count <= COUNT_LAST;
          end
        end
        INIT_LOAD: begin
          if (init_count == '0) begin
            init_state <= INIT_IDLE; // [R1]
          end else begin
            init_count <= init_count - 1'b1;
          end
        end
        default: begin
          init_state <= INIT_IDLE;
        end
      endcase
    end
  end

  assign init_busy = init_state == INIT_LOAD;

  // ****************************************************************
  // recovery page registers
  // ****************************************************************
  logic [7:0] recovery_page_reset;
  logic [7:2] loss_reserved;
  logic [7:0] manual_boost_control;
  logic [7:0] reserved_four;
  logic [7:0] reserved_five;
  logic [7:0] boost_override;
  logic [7:0] event_mask;
  logic recovery_page_clear;

  // a set clear bit restores the page one cycle later, itself included
  assign recovery_page_clear = recovery_page_reset[PAGE_CLEAR_BIT] ||
                               init_finish; // [R7]

  always_ff @(posedge clock) begin
    if (!rst_n || recovery_page_clear) begin
      recovery_page_reset <= RECOVERY_PAGE_RESET_RESET; // [R7]
      loss_reserved <= SIGNAL_LOSS_STATUS_RESET[7:2];
      manual_boost_control <= MANUAL_BOOST_CONTROL_RESET;
      reserved_four <= RESERVED_FOUR_RESET;
      reserved_five <= RESERVED_FIVE_RESET;
      boost_override <= BOOST_OVERRIDE_RESET;
      event_mask <= EVENT_MASK_RESET;
    end else if (recovery_write) begin
      unique case (host_access.address)
        RECOVERY_PAGE_RESET_OFFSET: begin
          recovery_page_reset <= host_access.write_data; // [R7]
        end
        SIGNAL_LOSS_STATUS_OFFSET: begin
          loss_reserved <= host_access.write_data[7:2]; // [R15]
        end
        MANUAL_BOOST_CONTROL_OFFSET: begin
          manual_boost_control <= host_access.write_data; // [R12]
        end
        RESERVED_FOUR_OFFSET: begin
          reserved_four <= host_access.write_data; // [R15]
        end
        RESERVED_FIVE_OFFSET: begin
          reserved_five <= host_access.write_data; // [R15]
        end
        BOOST_OVERRIDE_OFFSET: begin
          boost_override <= host_access.write_data; // [R11]
        end
        EVENT_MASK_OFFSET: begin
          event_mask <= host_access.write_data;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // applied boost and status views
  // ****************************************************************
  logic [7:0] next_applied_boost;
  logic [7:0] recovery_status;

  assign next_applied_boost = boost_in_use(boost_override[OVERRIDE_BIT],
                                           manual_boost_control,
                                           adaptive_boost);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      applied_boost <= '0;
      recovery_status <= RECOVERY_LOOP_STATUS_RESET;
    end else begin
      applied_boost <= next_applied_boost; // [R11] [R13]
      recovery_status <=
        status_sources[shared_status_select[STATUS_SELECT_LSB +: 4]]; // [R10]
    end
  end

  // ****************************************************************
  // lock indicator pin
  // ****************************************************************
  pcrb_pin_mode_type pin_mode;
  logic next_lock_n;

  assign pin_mode =
    pcrb_pin_mode_type'(page_and_pin_control[PIN_SELECT_LSB +: 2]);

  always_comb begin
    next_lock_n = 1'b1;
    unique case (pin_mode)
      PIN_LOCK: next_lock_n = !lock_synced; // [R4]
      PIN_RESERVED: next_lock_n = 1'b1; // [R4]
      PIN_LOSS: next_lock_n = !loss_synced; // [R4]
      PIN_EVENTS: begin
        next_lock_n = ~|(events_synced & event_mask[EVENT_COUNT-1:0]); // [R4]
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lock_n <= 1'b1;
    end else begin
      lock_n <= next_lock_n;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [7:0] next_read_data;

  always_comb begin
    next_read_data = 8'h00;
    unique case (target)
      TARGET_SHARED: begin
        unique case (host_access.address)
          SHARED_STATUS_SELECT_OFFSET: next_read_data = shared_status_select;
          SHARED_INIT_CONTROL_OFFSET: begin
            next_read_data = {3'h0, !init_busy, init_reserved,
                              init_trigger}; // [R1]
          end
          REVISION_CODE_OFFSET: next_read_data = REVISION_VALUE; // [R3]
          PART_IDENTIFIER_OFFSET: next_read_data = IDENTIFIER_VALUE; // [R3]
          PAGE_AND_PIN_CONTROL_OFFSET: next_read_data = page_and_pin_control;
          default: next_read_data = 8'h00;
        endcase
      end
      TARGET_RECOVERY: begin
        unique case (host_access.address)
          RECOVERY_PAGE_RESET_OFFSET: next_read_data = recovery_page_reset;
          SIGNAL_LOSS_STATUS_OFFSET: begin
            next_read_data = {loss_reserved, loss_synced,
                              SIGNAL_LOSS_STATUS_RESET[0]}; // [R9]
          end
          RECOVERY_LOOP_STATUS_OFFSET: next_read_data = recovery_status;
          MANUAL_BOOST_CONTROL_OFFSET: next_read_data = manual_boost_control;
          RESERVED_FOUR_OFFSET: next_read_data = reserved_four;
          RESERVED_FIVE_OFFSET: next_read_data = reserved_five;
          BOOST_OVERRIDE_OFFSET: next_read_data = boost_override;
          APPLIED_BOOST_OFFSET: next_read_data = applied_boost; // [R13]
          EVENT_MASK_OFFSET: next_read_data = event_mask;
          default: next_read_data = 8'h00;
        endcase
      end
      TARGET_DRIVER: next_read_data = 8'h00;
      TARGET_NONE: next_read_data = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      read_data <= 8'h00;
      read_valid <= 1'b0;
    end else begin
      read_valid <= host_access.read;
      if (host_access.read) begin
        read_data <= next_read_data;
      end
    end
  end

endmodule : pcrb_bank

`default_nettype wire

// ### pcrb_monitor.sv
// port checker of the paged control register bank
`timescale 1ns/10ps
`default_nettype none

module pcrb_monitor #(
  parameter logic [7:0] REVISION_VALUE = 8'h5A,
  parameter logic [7:0] IDENTIFIER_VALUE = 8'hA5,
  parameter int INIT_CYCLES = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire pcrb_pkg::pcrb_access_type host_access,
  input wire logic [7:0] read_data,
  input wire logic read_valid,
  input wire logic recovery_lock,
  input wire logic first_input_loss,
  input wire logic lock_n,
  input wire logic [7:0] applied_boost,
  input wire logic init_busy
);
  import pcrb_pkg::*;
  logic [7:0] page_ctl;
  int busy_count;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ****
  // shadow of page control and load length counter
  // ****
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      page_ctl <= PAGE_AND_PIN_CONTROL_RESET;
    end else if (host_access.write &&
                 host_access.address == PAGE_AND_PIN_CONTROL_OFFSET) begin
      page_ctl <= host_access.write_data;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n || !init_busy) begin
      busy_count <= 0;
    end else begin
      busy_count <= busy_count + 1;
    end
  end

  // ****
  // sequences
  // ****
  sequence shared_read(logic [7:0] addr);
    host_access.read && !page_ctl[PAGE_ENABLE_BIT] &&
      host_access.address == addr;
  endsequence
  sequence recovery_read(logic [7:0] addr);
    host_access.read && page_ctl[2:0] == 3'h4 && host_access.address == addr;
  endsequence
  sequence bad_page_read;
    host_access.read && page_ctl[PAGE_ENABLE_BIT] && page_ctl[1:0] != 2'h0 &&
      host_access.address != PAGE_AND_PIN_CONTROL_OFFSET;
  endsequence
  sequence init_trigger;
    host_access.write && !page_ctl[PAGE_ENABLE_BIT] && !init_busy &&
      host_access.address == 8'hE2 && host_access.write_data[0];
  endsequence

  // ****
  // assertions
  // ****
  chk_valid_follows: assert property (host_access.read |=> read_valid)
    else $error("read_valid missing after read");
  chk_valid_only_read: assert property (
    !host_access.read |=> !read_valid) else $error("read_valid without read");
  chk_init_starts: assert property (init_trigger |=> init_busy)
    else $error("load did not start");
  chk_init_length: assert property (
    $fell(init_busy) |-> busy_count == INIT_CYCLES)
    else $error("load length wrong");
  chk_init_flag: assert property (
    shared_read(8'hE2) |=> read_data[INIT_DONE_BIT] == !$past(init_busy))
    else $error("done flag wrong");
  chk_part_id: assert property (
    shared_read(PART_IDENTIFIER_OFFSET) |=> read_data == IDENTIFIER_VALUE)
    else $error("identifier wrong");
  chk_revision_read: assert property (
    shared_read(REVISION_CODE_OFFSET) |=> read_data == REVISION_VALUE)
    else $error("revision wrong");
  chk_bad_page: assert property (bad_page_read |=> read_data == 8'h00)
    else $error("other page read not zero");
  chk_boost_readback: assert property (
    recovery_read(APPLIED_BOOST_OFFSET) |=> read_data == $past(applied_boost))
    else $error("applied boost readback wrong");
  chk_reserved_pin: assert property (
    (page_ctl[5:4] == 2'b01)[*3] |-> lock_n)
    else $error("reserved mode pin low");
  chk_lock_pin: assert property (
    (page_ctl[5:4] == 2'b00 && recovery_lock)[*8] |-> !lock_n)
    else $error("lock not shown on pin");
  chk_loss_pin: assert property (
    (page_ctl[5:4] == 2'b10 && first_input_loss)[*8] |-> !lock_n)
    else $error("loss not shown on pin");
  chk_reset_state: assert property (
    $rose(rst_n) |-> lock_n && !init_busy && !read_valid && !applied_boost)
    else $error("outputs wrong after reset");
endmodule : pcrb_monitor

bind pcrb_bank pcrb_monitor #(
  .REVISION_VALUE(REVISION_VALUE),
  .IDENTIFIER_VALUE(IDENTIFIER_VALUE),
  .INIT_CYCLES(INIT_CYCLES)
) i_pcrb_monitor (
  .clock(clock),
  .rst_n(rst_n),
  .host_access(host_access),
  .read_data(read_data),
  .read_valid(read_valid),
  .recovery_lock(recovery_lock),
  .first_input_loss(first_input_loss),
  .lock_n(lock_n),
  .applied_boost(applied_boost),
  .init_busy(init_busy)
);

`default_nettype wire

// ### pcrb_host_model.sv
// host controller model driving the register access port
`timescale 1ns/10ps
`default_nettype none

module pcrb_host_model (
  input wire logic clock,
  output var pcrb_pkg::pcrb_access_type host_access,
  input wire logic [7:0] read_data,
  input wire logic read_valid,
  input wire logic init_busy
);
  import pcrb_pkg::*;
  initial host_access = '0;

  // released address and data lines show the inverse, never the old value
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock);
    host_access = '{1'b1, 1'b0, addr, data};
    @(negedge clock);
    host_access = '{1'b0, 1'b0, ~addr, ~data};
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clock);
    host_access = '{1'b0, 1'b1, addr, 8'h00};
    @(negedge clock);
    host_access = '{1'b0, 1'b0, ~addr, 8'hFF};
    data = read_valid === 1'b1 ? read_data : 8'hXX;
  endtask : read_reg

  // only the two documented page codes are ever built here
  task automatic set_page(input logic [1:0] mode, input logic en,
                          input logic code);
    write_reg(8'hFF, {2'b00, mode, 1'b0, en, 1'b0, code});
  endtask : set_page

  // reload settings after a page clear, waiting out the load
  task automatic restart_settings();
    write_reg(8'hE2, 8'h01);
    repeat (100) if (init_busy === 1'b1) @(negedge clock);
  endtask : restart_settings
endmodule : pcrb_host_model

`default_nettype wire

// ### testbench.sv
// self-checking testbench of the paged control register bank
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import pcrb_pkg::*;
  logic clock;
  logic rst_n;
  pcrb_access_type host_access;
  logic [7:0] read_data;
  logic read_valid;
  logic recovery_lock;
  logic first_input_loss;
  logic [15:0][7:0] status_sources;
  logic [7:0] adaptive_boost;
  logic [EVENT_COUNT-1:0] event_sources;
  logic lock_n;
  logic [7:0] applied_boost;
  logic init_busy;
  logic [3:0] pin_exp;
  int fail_count;
  int compares;

  pcrb_bank #(.INIT_CYCLES(8)) i_pcrb_bank (
    .clock(clock), .rst_n(rst_n), .host_access(host_access),
    .read_data(read_data), .read_valid(read_valid),
    .recovery_lock(recovery_lock), .first_input_loss(first_input_loss),
    .status_sources(status_sources), .adaptive_boost(adaptive_boost),
    .event_sources(event_sources), .lock_n(lock_n),
    .applied_boost(applied_boost), .init_busy(init_busy));
  pcrb_host_model host (
    .clock(clock), .host_access(host_access), .read_data(read_data),
    .read_valid(read_valid), .init_busy(init_busy));

  always #5 clock = ~clock;

  // ****
  // helpers
  // ****
  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : check

  task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(addr, d);
    check($sformatf("reg %h", addr), exp, d);
  endtask : expect_reg

  task automatic settle();
    repeat (8) @(negedge clock);
  endtask : settle

  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    end_sim();
  end

  // ****
  // tests
  // ****
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    fail_count = 0;
    compares = 0;
    recovery_lock = 1'b1;
    first_input_loss = 1'b0;
    adaptive_boost = 8'h6C;
    event_sources = 7'h01;
    for (int i = 0; i < 16; i++) status_sources[i] = 8'h10 + 8'(i);
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    settle();
    expect_reg(8'hE2, SHARED_INIT_CONTROL_RESET);
    expect_reg(8'hF0, 8'h5A);
    host.write_reg(8'hF1, 8'h00);
    expect_reg(8'hF1, 8'hA5);
    expect_reg(8'hFF, 8'h00);
    $display("test reset_values done");
    host.set_page(2'b00, 1'b1, 1'b0);
    host.write_reg(8'h03, 8'h3C);
    host.set_page(2'b00, 1'b0, 1'b0);
    host.write_reg(8'hE2, 8'h01);
    check("init_busy", 8'h01, {7'h00, init_busy});
    expect_reg(8'hE2, 8'h01);
    for (int i = 0; i < 40 && init_busy !== 1'b0; i++) @(negedge clock);
    expect_reg(8'hE2, 8'h10);
    host.set_page(2'b00, 1'b1, 1'b0);
    expect_reg(8'h03, 8'h80);
    $display("test init_sequence done");
    expect_reg(8'h01, 8'h01);
    expect_reg(8'h02, 8'h10);
    expect_reg(8'hF1, 8'h00);
    host.write_reg(8'h04, 8'h5A);
    expect_reg(8'h04, 8'h5A);
    first_input_loss = 1'b1;
    settle();
    expect_reg(8'h01, 8'h03);
    host.set_page(2'b00, 1'b0, 1'b0);
    host.write_reg(8'h0C, 8'h30);
    host.set_page(2'b00, 1'b1, 1'b0);
    expect_reg(8'h02, 8'h13);
    host.write_reg(8'h03, 8'h1B);
    expect_reg(8'h52, 8'h6C);
    host.write_reg(8'h2D, 8'h08);
    expect_reg(8'h52, 8'h1B);
    check("applied_boost", 8'h1B, applied_boost);
    $display("test paging_and_boost done");
    host.write_reg(8'h00, 8'h04);
    expect_reg(8'h00, 8'h00);
    expect_reg(8'h03, 8'h80);
    expect_reg(8'h2D, 8'h00);
    expect_reg(8'h04, 8'h00);
    expect_reg(8'h52, 8'h6C);
    host.set_page(2'b00, 1'b0, 1'b0);
    host.restart_settings();
    host.write_reg(8'hFF, 8'h05);
    host.write_reg(8'h03, 8'h55);
    expect_reg(8'h03, 8'h00);
    host.write_reg(8'hFF, 8'h06);
    expect_reg(8'h03, 8'h00);
    host.set_page(2'b00, 1'b1, 1'b0);
    expect_reg(8'h03, 8'h80);
    $display("test clear_and_pages done");
    first_input_loss = 1'b0;
    pin_exp = 4'b1110;
    for (int m = 0; m < 4; m++) begin
      host.set_page(2'(m), 1'b0, 1'b0);
      settle();
      check("lock_n", {7'h00, pin_exp[m]}, {7'h00, lock_n});
    end
    first_input_loss = 1'b1;
    host.set_page(2'b10, 1'b0, 1'b0);
    settle();
    check("lock_n", 8'h00, {7'h00, lock_n});
    host.set_page(2'b11, 1'b1, 1'b0);
    host.write_reg(8'h56, 8'h01);
    settle();
    check("lock_n", 8'h00, {7'h00, lock_n});
    $display("test lock_pin done");
    rst_n = 1'b0;
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    settle();
    expect_reg(8'hFF, 8'h00);
    expect_reg(8'hF1, 8'hA5);
    $display("test second_reset done");
    end_sim();
  end
endmodule : testbench

`default_nettype wire
